// *** rtl/sac_security_ctl.sv ***
// security level tracking, key handling and settings-edit mode control
// assumes the serial responder presents one byte access per cycle on reg_req,
// and that security straps and signature engine results are steady inputs
// Function
// - entering settings edit forces every protection fet off
// - edit flag shows in status once active; host waits for it
// - edit mode halts measurement and protection monitoring
// - leave command exits edit and reloads the new settings
// - edit entry accepted only at full access
// - sealed: status readable, selected writes only, no data memory access
// - unsealed adds extra subcommands and data memory reads
// - full access allows every setting and otp programming
// - level in status: sealed 11, unsealed 10, full 01, 00 unloaded
// - full access reached only from unsealed, or at boot when the seal strap is clear
// - key command moves four big endian key words, eight bytes
// - second key must come within 4 s of the first
// - key read: command 0x0035 fills transfer buffer with key bytes when not sealed
// - key write: buffer, inverted-sum checksum, then length 0x0a
// - seal strap seals at boot; seal command seals any time
// - config lock rejects all data memory changes, even in edit
// - permanent seal refuses every unseal once sealed
// - rom signature commands return the code and default rom signatures
// - static signature compared to stored; msb set on mismatch
`timescale 1ns/1ps
module sac_security_ctl #(
	parameter int unsigned KEY_WINDOW_CYC = sac_pkg::KEY_WINDOW_CYC
) (
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire sac_pkg::sac_reg_req_t reg_req,
	output logic [7:0]                 reg_rdata,
	input  wire sac_pkg::sac_sec_cfg_t sec_cfg,
	input  wire sac_pkg::sac_sig_in_t  sig_in,
	output sac_pkg::sac_level_t        access_level,
	output logic                       settings_edit_active_flag,
	output logic                       prot_fets_force_off,
	output logic                       measure_run,
	output logic                       settings_reload,
	output logic                       dm_read_allow,
	output logic                       dm_write_allow,
	output logic                       otp_write_allow,
	output logic                       extra_cmd_allow
);
	localparam int TW = sac_pkg::TMR_W;

	// ==========================================
	// decode
	sac_pkg::sac_level_t level;
	sac_pkg::sac_sec_cfg_t cfg_q;
	logic [7:0]        sub_lo;
	logic [7:0]        sub_hi;
	logic              lo_fresh;
	logic [15:0]       key_mem [sac_pkg::KEY_WORDS];
	logic [7:0]        xbuf [sac_pkg::XBUF_BYTES];
	logic [7:0]        cksum_q;
	logic              pend;
	logic              pend_full;
	logic [TW-1:0]     key_tmr;
	logic              edit;
	logic [15:0]       word;
	logic              word_ok;
	logic              second_ok;
	logic              key_step;
	logic              cmd_fire;
	logic              grant_unseal;
	logic              grant_full;
	logic              other_wr;
	logic [7:0]        xoff;
	logic              in_xbuf;
	logic [7:0]        sum;
	logic              key_wr_ok;
	logic [15:0]       status_word;
	logic [15:0]       static_res;

	assign word      = {reg_req.wdata, sub_lo};
	assign word_ok   = reg_req.wr && reg_req.addr == sac_pkg::A_SUB_HI && lo_fresh;
	assign other_wr  = reg_req.wr && reg_req.addr != sac_pkg::A_SUB_LO && reg_req.addr != sac_pkg::A_SUB_HI;
	assign second_ok = pend && key_tmr != '0 && word == (pend_full ? key_mem[3] : key_mem[1]);
	assign key_step  = second_ok || (!pend && (word == key_mem[0] || word == key_mem[2]));
	assign cmd_fire  = word_ok && !key_step;
	assign grant_unseal = word_ok && second_ok && !pend_full && level == sac_pkg::SAC_LVL_SEALED
		&& !cfg_q.permanent_lockdown_bit;
	assign grant_full = word_ok && second_ok && pend_full && level == sac_pkg::SAC_LVL_UNSEALED;
	assign xoff      = reg_req.addr - sac_pkg::A_XBUF;
	assign in_xbuf   = xoff < 8'(sac_pkg::XBUF_BYTES);

	// plain sum of command and data bytes; the checksum must equal its inverse
	always_comb begin
		sum = sac_pkg::CMD_KEYS[7:0] + sac_pkg::CMD_KEYS[15:8];
		for (int i = 0; i < sac_pkg::XBUF_BYTES; i++) begin
			sum = sum + xbuf[i];
		end
	end

	assign key_wr_ok = reg_req.wr && reg_req.addr == sac_pkg::A_LEN && reg_req.wdata == sac_pkg::KEY_LEN
		&& {sub_hi, sub_lo} == sac_pkg::CMD_KEYS && cksum_q == ~sum
		&& level == sac_pkg::SAC_LVL_FULL && !cfg_q.lock_cfg;

	assign static_res = {sig_in.static_calc[15] | (sig_in.static_calc != sig_in.static_stored),
		sig_in.static_calc[14:0]};

	always_comb begin
		status_word = '0;
		status_word[sac_pkg::ST_EDIT_BIT] = edit;
		status_word[sac_pkg::ST_LVL_LSB +: 2] = level;
	end

	// ==========================================
	// subcommand address pair
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sub_lo   <= 8'h00;
			sub_hi   <= 8'h00;
			lo_fresh <= 1'b0;
		end else if (reg_req.wr) begin
			lo_fresh <= reg_req.addr == sac_pkg::A_SUB_LO;
			if (reg_req.addr == sac_pkg::A_SUB_LO) begin
				sub_lo <= reg_req.wdata;
			end
			if (reg_req.addr == sac_pkg::A_SUB_HI) begin
				sub_hi <= reg_req.wdata;
			end
		end
	end

	// ==========================================
	// key sequence tracking
	// any write outside the pair breaks a pending sequence
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pend      <= 1'b0;
			pend_full <= 1'b0;
			key_tmr   <= '0;
		end else if (other_wr) begin
			pend <= 1'b0;
		end else if (word_ok) begin
			if (!pend && (word == key_mem[0] || word == key_mem[2])) begin
				pend      <= 1'b1;
				pend_full <= word == key_mem[2];
				key_tmr   <= TW'(KEY_WINDOW_CYC);
			end else begin
				pend <= 1'b0;
			end
		end else if (pend) begin
			if (key_tmr == '0) begin
				pend <= 1'b0;
			end else begin
				key_tmr <= key_tmr - 1'b1;
			end
		end
	end

	// ==========================================
	// security level; straps are caught on the first edge after release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			level <= sac_pkg::SAC_LVL_UNLOADED;
			cfg_q <= '0;
		end else if (level == sac_pkg::SAC_LVL_UNLOADED) begin
			cfg_q <= sec_cfg;
			level <= sec_cfg.seal_at_boot ? sac_pkg::SAC_LVL_SEALED : sac_pkg::SAC_LVL_FULL;
		end else if (cmd_fire && word == sac_pkg::CMD_SEAL) begin
			level <= sac_pkg::SAC_LVL_SEALED;
		end else if (grant_unseal) begin
			level <= sac_pkg::SAC_LVL_UNSEALED;
		end else if (grant_full) begin
			level <= sac_pkg::SAC_LVL_FULL;
		end
	end

	// ==========================================
	// settings edit mode; sealing also ends it
	// a seal out of edit restarts operation, so a sealed part never sits with monitoring halted
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			edit                <= 1'b0;
			prot_fets_force_off <= 1'b0;
			measure_run         <= 1'b0;
			settings_reload     <= 1'b0;
		end else begin
			settings_reload <= 1'b0;
			if (level == sac_pkg::SAC_LVL_UNLOADED) begin
				measure_run <= 1'b0;
			end else if (!edit && cmd_fire && word == sac_pkg::CMD_ENTER
				&& level == sac_pkg::SAC_LVL_FULL) begin
				edit                <= 1'b1;
				prot_fets_force_off <= 1'b1;
				measure_run         <= 1'b0;
			end else if (edit && cmd_fire && (word == sac_pkg::CMD_EXIT || word == sac_pkg::CMD_SEAL)) begin
				edit                <= 1'b0;
				prot_fets_force_off <= 1'b0;
				measure_run         <= 1'b1;
				settings_reload     <= 1'b1;
			end else if (!edit) begin
				measure_run <= 1'b1;
			end
		end
	end

	// ==========================================
	// permissions, registered one cycle behind the level
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dm_read_allow   <= 1'b0;
			dm_write_allow  <= 1'b0;
			otp_write_allow <= 1'b0;
			extra_cmd_allow <= 1'b0;
		end else begin
			dm_read_allow   <= level == sac_pkg::SAC_LVL_UNSEALED || level == sac_pkg::SAC_LVL_FULL;
			extra_cmd_allow <= level == sac_pkg::SAC_LVL_UNSEALED || level == sac_pkg::SAC_LVL_FULL;
			dm_write_allow  <= edit && !cfg_q.lock_cfg;
			otp_write_allow <= edit && level == sac_pkg::SAC_LVL_FULL && !cfg_q.lock_cfg;
		end
	end

	// ==========================================
	// keys
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			key_mem[0] <= sac_pkg::DEF_KEY0;
			key_mem[1] <= sac_pkg::DEF_KEY1;
			key_mem[2] <= sac_pkg::DEF_KEY2;
			key_mem[3] <= sac_pkg::DEF_KEY3;
		end else if (key_wr_ok) begin
			for (int i = 0; i < sac_pkg::KEY_WORDS; i++) begin
				key_mem[i] <= {xbuf[2*i], xbuf[2*i+1]};
			end
		end
	end

	// ==========================================
	// transfer buffer, checksum; commands that return data load it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < sac_pkg::XBUF_BYTES; i++) begin
				xbuf[i] <= 8'h00;
			end
			cksum_q <= 8'h00;
		end else if (cmd_fire && word == sac_pkg::CMD_KEYS && level != sac_pkg::SAC_LVL_SEALED) begin
			for (int i = 0; i < sac_pkg::KEY_WORDS; i++) begin
				xbuf[2*i]   <= key_mem[i][15:8];
				xbuf[2*i+1] <= key_mem[i][7:0];
			end
		end else if (cmd_fire && (word == sac_pkg::CMD_CROM || word == sac_pkg::CMD_DROM
			|| word == sac_pkg::CMD_SSIG)) begin
			for (int i = 2; i < sac_pkg::XBUF_BYTES; i++) begin
				xbuf[i] <= 8'h00;
			end
			unique case (word)
				sac_pkg::CMD_CROM: {xbuf[1], xbuf[0]} <= sig_in.code_rom;
				sac_pkg::CMD_DROM: {xbuf[1], xbuf[0]} <= sig_in.default_rom;
				default:           {xbuf[1], xbuf[0]} <= static_res;
			endcase
		end else if (reg_req.wr && in_xbuf) begin
			xbuf[xoff[sac_pkg::XBUF_AW-1:0]] <= reg_req.wdata;
		end else if (reg_req.wr && reg_req.addr == sac_pkg::A_CKSUM) begin
			cksum_q <= reg_req.wdata;
		end
	end

	// ==========================================
	// read port; unmapped addresses read zero
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			if (in_xbuf) begin
				reg_rdata <= xbuf[xoff[sac_pkg::XBUF_AW-1:0]];
			end else begin
				case (reg_req.addr)
					sac_pkg::A_STATUS_LO: reg_rdata <= status_word[7:0];
					sac_pkg::A_STATUS_HI: reg_rdata <= status_word[15:8];
					sac_pkg::A_SUB_LO:    reg_rdata <= sub_lo;
					sac_pkg::A_SUB_HI:    reg_rdata <= sub_hi;
					sac_pkg::A_CKSUM:     reg_rdata <= cksum_q;
					default:              reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	assign access_level              = level;
	assign settings_edit_active_flag = edit;

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_enter_needs_full: assert property ($rose(edit) |-> $past(level) == sac_pkg::SAC_LVL_FULL)
		else $error("edit entered below full access");
	a_edit_fets_off: assert property (edit |-> prot_fets_force_off && !measure_run)
		else $error("fets or measurement active in edit");
	a_exit_reload: assert property ($fell(edit) |-> settings_reload ##1 !settings_reload)
		else $error("no single reload pulse on exit");
	a_full_path: assert property ($changed(level) && level == sac_pkg::SAC_LVL_FULL
		&& $past(level) != sac_pkg::SAC_LVL_UNLOADED |-> $past(level) == sac_pkg::SAC_LVL_UNSEALED)
		else $error("full access not from unsealed");
	a_status_level: assert property (reg_req.rd && reg_req.addr == sac_pkg::A_STATUS_HI
		|=> reg_rdata[1:0] == $past(level))
		else $error("status level field wrong");
	a_seal_cmd: assert property (cmd_fire && word == sac_pkg::CMD_SEAL |=> level == sac_pkg::SAC_LVL_SEALED)
		else $error("seal command ignored");
	a_permanent_lockdown_bit: assert property (cfg_q.permanent_lockdown_bit && level == sac_pkg::SAC_LVL_SEALED
		|=> level == sac_pkg::SAC_LVL_SEALED)
		else $error("unsealed under permanent seal");
	a_lock_blocks: assert property (cfg_q.lock_cfg |=> !dm_write_allow && $stable(key_mem[0]))
		else $error("data memory write under lock");
	a_key_timeout: assert property (pend && key_tmr == '0 && !word_ok |=> !pend)
		else $error("key window not closed");
	a_break_seq: assert property (other_wr |=> !pend && $stable(level))
		else $error("interrupted key pair kept");
	a_sealed_no_dm: assert property (level == sac_pkg::SAC_LVL_SEALED [*2] |-> !dm_read_allow)
		else $error("data memory readable while sealed");
	a_key_read: assert property (cmd_fire && word == sac_pkg::CMD_KEYS && level != sac_pkg::SAC_LVL_SEALED
		|=> xbuf[0] == $past(key_mem[0][15:8]) && xbuf[7] == $past(key_mem[3][7:0]))
		else $error("key bytes not loaded");

	// status, key store, signature and seal-exit checks
	a_edit_status: assert property (reg_req.rd && reg_req.addr == sac_pkg::A_STATUS_LO
		|=> reg_rdata[sac_pkg::ST_EDIT_BIT] == $past(edit))
		else $error("edit flag wrong in status");
	a_key_write: assert property (key_wr_ok |=> key_mem[0] == {$past(xbuf[0]), $past(xbuf[1])}
		&& key_mem[3] == {$past(xbuf[6]), $past(xbuf[7])})
		else $error("keys not stored from buffer");
	a_code_sig: assert property (cmd_fire && word == sac_pkg::CMD_CROM
		|=> {xbuf[1], xbuf[0]} == $past(sig_in.code_rom))
		else $error("code rom signature not returned");
	a_static_msb: assert property (cmd_fire && word == sac_pkg::CMD_SSIG
		&& sig_in.static_calc != sig_in.static_stored |=> xbuf[1][7])
		else $error("static mismatch msb clear");
	a_seal_edit: assert property (edit && cmd_fire && word == sac_pkg::CMD_SEAL
		|=> !edit && settings_reload && level == sac_pkg::SAC_LVL_SEALED)
		else $error("seal did not end edit");

	c_edit: cover property ($rose(edit) ##[1:1000] $fell(edit));
	c_unseal: cover property (grant_unseal);
	c_full: cover property (grant_full);
	c_key_write: cover property (key_wr_ok);

endmodule // sac_security_ctl

// *** rtl/sac_pkg.sv ***
// constants and types for the security-level and settings-edit controller
// assumes one 10 MHz system clock and a byte-wide register port from the serial link
package sac_pkg;

	// ==========================================
	// register map
	localparam logic [7:0] A_STATUS_LO = 8'h12;
	localparam logic [7:0] A_STATUS_HI = 8'h13;
	localparam logic [7:0] A_SUB_LO    = 8'h3e;
	localparam logic [7:0] A_SUB_HI    = 8'h3f;
	localparam logic [7:0] A_XBUF      = 8'h40;
	localparam logic [7:0] A_CKSUM     = 8'h60;
	localparam logic [7:0] A_LEN       = 8'h61;
	localparam int         XBUF_BYTES  = 8;
	localparam int         XBUF_AW     = 3;
	localparam int         KEY_WORDS   = 4;

	// status word fields
	localparam int ST_EDIT_BIT = 0;
	localparam int ST_LVL_LSB  = 8;

	// ==========================================
	// subcommands
	localparam logic [15:0] CMD_ENTER = 16'h0090;
	localparam logic [15:0] CMD_EXIT  = 16'h0092;
	localparam logic [15:0] CMD_SEAL  = 16'h0030;
	localparam logic [15:0] CMD_KEYS  = 16'h0035;
	localparam logic [15:0] CMD_CROM  = 16'h0004;
	localparam logic [15:0] CMD_DROM  = 16'h0009;
	localparam logic [15:0] CMD_SSIG  = 16'h0005;
	localparam logic [7:0]  KEY_LEN   = 8'h0a;

	// default keys, arbitrary values
	localparam logic [15:0] DEF_KEY0 = 16'h1234;
	localparam logic [15:0] DEF_KEY1 = 16'h5678;
	localparam logic [15:0] DEF_KEY2 = 16'h9abc;
	localparam logic [15:0] DEF_KEY3 = 16'hdef0;

	// ==========================================
	// timing
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned KEY_WINDOW_S   = 4;
	localparam int unsigned KEY_WINDOW_CYC = KEY_WINDOW_S * CLK_HZ;
	localparam int          TMR_W          = 26;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		SAC_LVL_UNLOADED = 2'b00,
		SAC_LVL_FULL     = 2'b01,
		SAC_LVL_UNSEALED = 2'b10,
		SAC_LVL_SEALED   = 2'b11
	} sac_level_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sac_reg_req_t;

	typedef struct packed {
		logic seal_at_boot;
		logic lock_cfg;
		logic permanent_lockdown_bit;
	} sac_sec_cfg_t;

	typedef struct packed {
		logic [15:0] code_rom;
		logic [15:0] default_rom;
		logic [15:0] static_calc;
		logic [15:0] static_stored;
	} sac_sig_in_t;

endpackage

// *** sim/sac_host_model.sv ***
// host-side model: issues byte accesses, key words and key loads to the controller
// assumes the controller takes one access per clk_sys edge and answers a read one edge later
`timescale 1ns/1ps
module sac_host_model (
	input  wire logic             clk_sys,
	output sac_pkg::sac_reg_req_t reg_req,
	input  wire logic [7:0]       reg_rdata
);
	initial reg_req = '0;

	// ==========================================
	// byte accesses
	// released address and data lines show the inverse of the last value, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
		#1 d = reg_rdata;
	endtask

	// ==========================================
	// subcommand words and key loads
	task automatic word(input logic [15:0] w);
		wr(sac_pkg::A_SUB_LO, w[7:0]);
		wr(sac_pkg::A_SUB_HI, w[15:8]);
	endtask

	task automatic load_keys(input logic [63:0] keys);
		logic [7:0] sum;
		sum = 8'h35;
		word(sac_pkg::CMD_KEYS);
		for (int i = 0; i < 8; i++) begin
			wr(sac_pkg::A_XBUF + 8'(i), keys[63-8*i -: 8]);
			sum = sum + keys[63-8*i -: 8];
		end
		wr(sac_pkg::A_CKSUM, ~sum);
		wr(sac_pkg::A_LEN, sac_pkg::KEY_LEN);
	endtask
endmodule // sac_host_model

// *** sim/testbench.sv ***
// self-checking bench for the security-level and settings-edit controller
// assumes the host model drives the register port; straps and signatures come from here
`timescale 1ns/1ps
module testbench;
	localparam int unsigned WIN = 50;
	localparam logic [15:0] SCMD [3] = '{sac_pkg::CMD_CROM, sac_pkg::CMD_DROM, sac_pkg::CMD_SSIG};
	localparam logic [15:0] SEXP [3] = '{16'ha55a, 16'h3cc3, 16'h8123};
	logic                  clk_sys;
	logic                  resetn;
	sac_pkg::sac_reg_req_t reg_req;
	logic [7:0]            reg_rdata;
	sac_pkg::sac_sec_cfg_t sec_cfg;
	sac_pkg::sac_sig_in_t  sig_in;
	sac_pkg::sac_level_t   access_level;
	logic                  edit, fets_off, meas, reload, dm_rd, dm_wr, otp_wr, extra;
	int                    fail_count, cmp_count, reload_cnt, n;
	logic [7:0]            rb;
	logic [63:0]           new_keys;

	sac_host_model u_sac_host_model (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

	sac_security_ctl #(.KEY_WINDOW_CYC(WIN)) u_sac_security_ctl (
		.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.sec_cfg(sec_cfg), .sig_in(sig_in), .access_level(access_level),
		.settings_edit_active_flag(edit), .prot_fets_force_off(fets_off), .measure_run(meas),
		.settings_reload(reload), .dm_read_allow(dm_rd), .dm_write_allow(dm_wr),
		.otp_write_allow(otp_wr), .extra_cmd_allow(extra));

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (reload === 1'b1) reload_cnt++;

	// ==========================================
	// helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask

	task automatic pair(input logic [15:0] a, input logic [15:0] b);
		u_sac_host_model.word(a);
		u_sac_host_model.word(b);
		idle(3);
	endtask

	task automatic do_reset(input sac_pkg::sac_sec_cfg_t cfg);
		@(posedge clk_sys);
		resetn <= 1'b0;
		sec_cfg <= cfg;
		idle(10);
		chk(access_level, 2'b00, "lvl in reset");
		chk({meas, edit, fets_off}, 3'b000, "outs in reset");
		@(posedge clk_sys);
		resetn <= 1'b1;
		idle(3);
	endtask

	task automatic keys_read(input logic [63:0] exp);
		u_sac_host_model.word(sac_pkg::CMD_KEYS);
		for (int i = 0; i < 8; i++) begin
			u_sac_host_model.rd(sac_pkg::A_XBUF + 8'(i), rb);
			chk(rb, exp[63-8*i -: 8], "key byte");
		end
	endtask

	task automatic edit_cycle(input logic [1:0] exp_wr);
		u_sac_host_model.word(sac_pkg::CMD_ENTER);
		n = 0;
		rb = 8'h00;
		while (rb[0] !== 1'b1 && n < 20) begin
			u_sac_host_model.rd(sac_pkg::A_STATUS_LO, rb);
			n++;
		end
		if (rb[0] !== 1'b1) begin
			chk(rb, 8'h01, "edit flag wait");
			end_of_test();
		end
		chk({edit, fets_off, meas}, 3'b110, "edit active");
		chk({dm_wr, otp_wr}, exp_wr, "edit writes");
		n = reload_cnt;
		u_sac_host_model.word(sac_pkg::CMD_EXIT);
		idle(4);
		chk({edit, fets_off, meas}, 3'b001, "edit left");
		chk(reload_cnt - n, 1, "reload pulse");
	endtask

	// ==========================================
	// main sequence
	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		sec_cfg = '0;
		sig_in = '{16'ha55a, 16'h3cc3, 16'h0123, 16'h0456};
		fail_count = 0;
		cmp_count = 0;
		reload_cnt = 0;
		new_keys = 64'h1111_2222_3333_4444;
		do_reset('{1'b1, 1'b0, 1'b0});
		chk(access_level, sac_pkg::SAC_LVL_SEALED, "boot sealed");
		u_sac_host_model.rd(sac_pkg::A_STATUS_HI, rb);
		chk(rb, 8'h03, "status sealed");
		chk({dm_rd, extra, meas}, 3'b001, "sealed perms");
		u_sac_host_model.word(sac_pkg::CMD_ENTER);
		idle(3);
		chk(edit, 1'b0, "edit refused sealed");
		pair(sac_pkg::DEF_KEY2, sac_pkg::DEF_KEY3);
		chk(access_level, sac_pkg::SAC_LVL_SEALED, "full from sealed");
		pair(sac_pkg::DEF_KEY0, sac_pkg::DEF_KEY1);
		chk(access_level, sac_pkg::SAC_LVL_UNSEALED, "unseal");
		chk({dm_rd, extra, otp_wr}, 3'b110, "unsealed perms");
		u_sac_host_model.rd(sac_pkg::A_STATUS_HI, rb);
		chk(rb, 8'h02, "status unsealed");
		u_sac_host_model.word(sac_pkg::CMD_ENTER);
		idle(3);
		chk(edit, 1'b0, "edit refused unsealed");
		u_sac_host_model.word(sac_pkg::DEF_KEY2);
		u_sac_host_model.wr(sac_pkg::A_XBUF, 8'h00);
		u_sac_host_model.word(sac_pkg::DEF_KEY3);
		idle(3);
		chk(access_level, sac_pkg::SAC_LVL_UNSEALED, "interrupted pair");
		pair(sac_pkg::DEF_KEY2, sac_pkg::DEF_KEY1);
		chk(access_level, sac_pkg::SAC_LVL_UNSEALED, "wrong word");
		u_sac_host_model.word(sac_pkg::DEF_KEY2);
		idle(WIN + 5);
		u_sac_host_model.word(sac_pkg::DEF_KEY3);
		idle(3);
		chk(access_level, sac_pkg::SAC_LVL_UNSEALED, "late second key");
		pair(sac_pkg::DEF_KEY2, sac_pkg::DEF_KEY3);
		chk(access_level, sac_pkg::SAC_LVL_FULL, "full access");
		u_sac_host_model.rd(sac_pkg::A_STATUS_HI, rb);
		chk(rb, 8'h01, "status full");
		keys_read({sac_pkg::DEF_KEY0, sac_pkg::DEF_KEY1, sac_pkg::DEF_KEY2, sac_pkg::DEF_KEY3});
		edit_cycle(2'b11);
		u_sac_host_model.load_keys(new_keys);
		keys_read(new_keys);
		for (int i = 0; i < 3; i++) begin
			u_sac_host_model.word(SCMD[i]);
			u_sac_host_model.rd(sac_pkg::A_XBUF, rb);
			chk(rb, SEXP[i][7:0], "sig lo");
			u_sac_host_model.rd(sac_pkg::A_XBUF + 8'h01, rb);
			chk(rb, SEXP[i][15:8], "sig hi");
		end
		u_sac_host_model.word(sac_pkg::CMD_SEAL);
		idle(3);
		chk(access_level, sac_pkg::SAC_LVL_SEALED, "seal cmd");
		pair(16'h1111, 16'h2222);
		chk(access_level, sac_pkg::SAC_LVL_UNSEALED, "unseal new keys");
		do_reset('{1'b0, 1'b1, 1'b1});
		chk(access_level, sac_pkg::SAC_LVL_FULL, "boot full");
		edit_cycle(2'b00);
		u_sac_host_model.word(sac_pkg::CMD_ENTER);
		n = reload_cnt;
		u_sac_host_model.word(sac_pkg::CMD_SEAL);
		idle(3);
		chk({edit, fets_off, meas, access_level}, 5'b00111, "seal ends edit");
		chk(reload_cnt - n, 1, "seal reload");
		pair(sac_pkg::DEF_KEY0, sac_pkg::DEF_KEY1);
		chk(access_level, sac_pkg::SAC_LVL_SEALED, "permanent_lockdown_bit holds");
		end_of_test();
	end
endmodule // testbench
